// [verilog/acrb_pkg.sv]
// register map, field layout and carrier types for the adc config register bank
// assumes: 8-bit addresses and data from the serial port front end
package acrb_pkg;
   localparam logic [7:0] ADDR_PORT_CFG  = 8'h00;
   localparam logic [7:0] ADDR_PART_ID   = 8'h01;
   localparam logic [7:0] ADDR_GRADE     = 8'h02;
   localparam logic [7:0] ADDR_PWR_MODE  = 8'h08;
   localparam logic [7:0] ADDR_CLK_COND  = 8'h09;
   localparam logic [7:0] ADDR_TRANSFER  = 8'hFF;

   localparam logic [7:0] RST_PORT_CFG   = 8'h18;
   localparam logic [7:0] RST_PWR_MODE   = 8'h00;
   localparam logic [7:0] RST_CLK_COND   = 8'h01;
   localparam logic [7:0] RST_TRANSFER   = 8'h00;
   // arbitrary identifier value, not tied to any real part
   localparam logic [7:0] PART_ID_VALUE  = 8'h5A;
   // grade code zero is the 150 MSPS grade
   localparam logic       GRADE_CODE     = 1'b0;

   localparam logic [7:0] PORT_CFG_FIXED = 8'h18;
   localparam logic [7:0] PORT_CFG_WMASK = 8'h66;
   localparam logic [7:0] PWR_MODE_WMASK = 8'h27;
   localparam logic [7:0] CLK_COND_WMASK = 8'h01;
   localparam logic [7:0] TRANSFER_WMASK = 8'h01;
   localparam int         GRADE_BIT      = 3;
   localparam int         PIN_MODE_BIT   = 5;
   localparam int         LSB_FIRST_LO   = 1;
   localparam int         LSB_FIRST_HI   = 6;
   localparam int         SOFT_RST_LO    = 2;
   localparam int         SOFT_RST_HI    = 5;
   localparam logic [2:0] PM_NORMAL_A    = 3'h0;
   localparam logic [2:0] PM_FULL_DOWN   = 3'h1;
   localparam logic [2:0] PM_STANDBY     = 3'h2;

   typedef enum logic [1:0] {
      ACRB_PWR_NORMAL,
      ACRB_PWR_FULL_DOWN,
      ACRB_PWR_STANDBY
   } acrb_pwr_t;

   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } acrb_req_t;

   typedef struct packed {
      acrb_pwr_t  pwr;
      logic       dcs_en;
      logic       lsb_first;
   } acrb_ctrl_t;
endpackage : acrb_pkg

// [verilog/acrb_sync.sv]
// two flip-flop level synchroniser
// assumes: input is asynchronous to clk_i
module acrb_sync (
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic d_i,
   output logic      q_o
);
   logic meta;
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta <= 1'b0;
         q_o  <= 1'b0;
      end else begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule : acrb_sync

// [verilog/acrb_link.sv]
// link-clock side: catches one access per frame and hands it over by toggle
// assumes: the serial front end presents a complete access with a one-cycle strobe on link_clk_i
module acrb_link
   import acrb_pkg::*;
(
   input  wire logic      link_clk_i,
   input  wire logic      link_rst_b_i,
   input  wire logic      acc_stb_i,
   input  wire acrb_req_t acc_req_i,
   output logic           tgl_o,
   output acrb_req_t      req_o
);
   import acrb_pkg::*;
   // request held stable while the toggle crosses
   always_ff @(posedge link_clk_i or negedge link_rst_b_i) begin
      if (!link_rst_b_i) begin
         tgl_o <= 1'b0;
         req_o <= '0;
      end else if (acc_stb_i) begin
         tgl_o <= ~tgl_o;
         req_o <= acc_req_i;
      end
   end
endmodule : acrb_link

// [verilog/acrb_bank.sv]
// adc configuration register bank behind the serial control port
// assumes: link side delivers accesses spaced at least 4 ref_clk cycles apart
module acrb_bank
   import acrb_pkg::*;
(
   input  wire logic       ref_clk_i,
   input  wire logic       rst_b_i,
   input  wire logic       clk_en_i,
   input  wire logic       link_clk_i,
   input  wire logic       acc_stb_i,
   input  wire acrb_req_t  acc_req_i,
   input  wire logic       power_down_pin_i,
   output logic [7:0]      rd_data_o,
   output logic            rd_valid_o,
   output acrb_ctrl_t      ctrl_o
);
   import acrb_pkg::*;

   logic       rst_s1;
   logic       rst_sync_b;
   logic       link_rst_s1;
   logic       link_rst_b;
   logic       tgl;
   acrb_req_t  link_req;
   logic       tgl_sync;
   logic       tgl_seen;
   logic       pin_sync;
   logic [7:0] port_cfg;
   logic [7:0] pwr_shadow;
   logic [7:0] clk_shadow;
   logic [7:0] pwr_active;
   logic [7:0] clk_active;
   logic [7:0] transfer;
   acrb_req_t  req_hold;

   // reset release, ref domain
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_s1     <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_s1     <= 1'b1;
         rst_sync_b <= rst_s1;
      end
   end

   // reset release, link domain
   always_ff @(posedge link_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         link_rst_s1 <= 1'b0;
         link_rst_b  <= 1'b0;
      end else begin
         link_rst_s1 <= 1'b1;
         link_rst_b  <= link_rst_s1;
      end
   end

   acrb_link u_link (
      .link_clk_i   (link_clk_i),
      .link_rst_b_i (link_rst_b),
      .acc_stb_i    (acc_stb_i),
      .acc_req_i    (acc_req_i),
      .tgl_o        (tgl),
      .req_o        (link_req)
   );

   acrb_sync u_tgl_sync (
      .clk_i   (ref_clk_i),
      .rst_b_i (rst_sync_b),
      .d_i     (tgl),
      .q_o     (tgl_sync)
   );

   acrb_sync u_pin_sync (
      .clk_i   (ref_clk_i),
      .rst_b_i (rst_sync_b),
      .d_i     (power_down_pin_i),
      .q_o     (pin_sync)
   );

   // new access arrives when synchronised toggle differs from last seen
   wire acc_new = clk_en_i && (tgl_sync != tgl_seen);
   wire acc_wr  = acc_new && link_req.wr;
   wire acc_rd  = acc_new && !link_req.wr;
   wire [7:0] wdata = link_req.data;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
      hit = (a == ref_a);
   endfunction : hit

   wire wr_port = acc_wr && hit(link_req.addr, ADDR_PORT_CFG);
   wire wr_pwr  = acc_wr && hit(link_req.addr, ADDR_PWR_MODE);
   wire wr_clk  = acc_wr && hit(link_req.addr, ADDR_CLK_COND);
   wire wr_xfer = acc_wr && hit(link_req.addr, ADDR_TRANSFER);

   wire soft_rst = port_cfg[SOFT_RST_LO] || port_cfg[SOFT_RST_HI];

   wire [7:0] next_port = (wdata & PORT_CFG_WMASK) | PORT_CFG_FIXED;

   wire [7:0] grade_val = 8'(GRADE_CODE) << GRADE_BIT;
   logic [7:0] rd_mux;
   always_comb begin
      if (hit(req_hold.addr, ADDR_PORT_CFG)) begin
         rd_mux = port_cfg;
      end else if (hit(req_hold.addr, ADDR_PART_ID)) begin
         rd_mux = PART_ID_VALUE;
      end else if (hit(req_hold.addr, ADDR_GRADE)) begin
         rd_mux = grade_val;
      end else if (hit(req_hold.addr, ADDR_PWR_MODE)) begin
         rd_mux = pwr_shadow;
      end else if (hit(req_hold.addr, ADDR_CLK_COND)) begin
         rd_mux = clk_shadow;
      end else if (hit(req_hold.addr, ADDR_TRANSFER)) begin
         rd_mux = transfer;
      end else begin
         rd_mux = 8'h00;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         tgl_seen   <= 1'b0;
         port_cfg   <= RST_PORT_CFG;
         pwr_shadow <= RST_PWR_MODE;
         clk_shadow <= RST_CLK_COND;
         pwr_active <= RST_PWR_MODE;
         clk_active <= RST_CLK_COND;
         transfer   <= RST_TRANSFER;
      end else if (clk_en_i) begin
         if (acc_new) begin
            tgl_seen <= tgl_sync;
         end
         if (soft_rst) begin
            port_cfg   <= RST_PORT_CFG;
            pwr_shadow <= RST_PWR_MODE;
            clk_shadow <= RST_CLK_COND;
            pwr_active <= RST_PWR_MODE;
            clk_active <= RST_CLK_COND;
            transfer   <= RST_TRANSFER;
         end else begin
            if (wr_port) begin
               port_cfg <= next_port;
            end
            if (wr_pwr) begin
               pwr_shadow <= wdata & PWR_MODE_WMASK;
            end
            if (wr_clk) begin
               clk_shadow <= wdata & CLK_COND_WMASK;
            end
            if (transfer[0]) begin
               pwr_active <= pwr_shadow;
               clk_active <= clk_shadow;
               transfer   <= RST_TRANSFER;
            end else if (wr_xfer) begin
               transfer <= wdata & TRANSFER_WMASK;
            end
         end
      end
   end

   acrb_pwr_t next_pwr;
   always_comb begin
      if (pin_sync) begin
         next_pwr = pwr_active[PIN_MODE_BIT] ? ACRB_PWR_STANDBY : ACRB_PWR_FULL_DOWN;
      end else begin
         case (pwr_active[2:0])
            PM_FULL_DOWN: next_pwr = ACRB_PWR_FULL_DOWN;
            PM_STANDBY:   next_pwr = ACRB_PWR_STANDBY;
            default:      next_pwr = ACRB_PWR_NORMAL;
         endcase
      end
   end

   logic acc_rd_d;
   always_ff @(posedge ref_clk_i or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         req_hold   <= '0;
         acc_rd_d   <= 1'b0;
         rd_data_o  <= 8'h00;
         rd_valid_o <= 1'b0;
         ctrl_o     <= '{pwr: ACRB_PWR_NORMAL, dcs_en: 1'b1, lsb_first: 1'b0};
      end else if (clk_en_i) begin
         if (acc_new) begin
            req_hold <= link_req;
         end
         acc_rd_d   <= acc_rd;
         rd_valid_o <= acc_rd_d;
         if (acc_rd_d) begin
            rd_data_o <= rd_mux;
         end
         ctrl_o.pwr <= next_pwr;
         ctrl_o.dcs_en    <= clk_active[0];
         ctrl_o.lsb_first <= port_cfg[LSB_FIRST_LO] | port_cfg[LSB_FIRST_HI];
      end
   end

   // chk_port_fixed_bits
   chk_port_fixed_bits: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (port_cfg & 8'h99) == 8'h18) else $error("port config fixed bits wrong");
   // chk_soft_rst_clear
   chk_soft_rst_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (soft_rst && clk_en_i) |=> (port_cfg == 8'h18 && pwr_shadow == 8'h00))
      else $error("soft reset did not restore");
   // chk_commit_copy
   chk_commit_copy: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (transfer[0] && clk_en_i && !soft_rst) |=> (pwr_active == $past(pwr_shadow)
      && transfer == 8'h00)) else $error("transfer did not commit");
   // chk_no_commit_hold
   chk_no_commit_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (!transfer[0] && !soft_rst) |=> $stable(clk_active)) else $error("active changed");
   // chk_pin_override
   chk_pin_override: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (pin_sync && clk_en_i && !pwr_active[5]) |=> ctrl_o.pwr == ACRB_PWR_FULL_DOWN)
      else $error("pin override failed");
   // chk_mode_standby
   chk_mode_standby: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (!pin_sync && clk_en_i && pwr_active[2:0] == 3'h2) |=> ctrl_o.pwr == ACRB_PWR_STANDBY)
      else $error("standby decode wrong");
   // chk_dcs_follow
   chk_dcs_follow: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      clk_en_i |=> ctrl_o.dcs_en == $past(clk_active[0])) else $error("dcs mismatch");
   // chk_id_readback
   chk_id_readback: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (acc_rd_d && clk_en_i && req_hold.addr == 8'h01) |=> rd_data_o == PART_ID_VALUE)
      else $error("id readback wrong");
   // chk_unused_zero
   chk_unused_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (clk_shadow[7:1] == 7'h00) && (pwr_shadow & 8'hD8) == 8'h00)
      else $error("unused bits set");
   chk_mode_full: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (!pin_sync && clk_en_i && pwr_active[2:0] == 3'h1)
      |=> ctrl_o.pwr == ACRB_PWR_FULL_DOWN) else $error("full down decode wrong");
   chk_mode_normal: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (!pin_sync && clk_en_i && (pwr_active[2:0] == 3'h0 || pwr_active[2:0] == 3'h3))
      |=> ctrl_o.pwr == ACRB_PWR_NORMAL) else $error("normal decode wrong");
   chk_pin_standby: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (pin_sync && clk_en_i && pwr_active[5]) |=> ctrl_o.pwr == ACRB_PWR_STANDBY)
      else $error("pin standby failed");
   chk_lsb_follow: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      clk_en_i |=> ctrl_o.lsb_first == ($past(port_cfg[1]) | $past(port_cfg[6])))
      else $error("lsb first mismatch");
   chk_rd_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (clk_en_i && rd_valid_o) |=> !rd_valid_o) else $error("read valid too long");
   chk_grade_readback: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (acc_rd_d && clk_en_i && req_hold.addr == 8'h02) |=> rd_data_o == 8'h00)
      else $error("grade readback wrong");
   chk_unmapped_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (acc_rd_d && clk_en_i && !(req_hold.addr inside {8'h00, 8'h01, 8'h02, 8'h08, 8'h09, 8'hFF}))
      |=> rd_data_o == 8'h00) else $error("unmapped read not zero");
   chk_port_write: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (wr_port && !soft_rst) |=> port_cfg == (($past(wdata) & 8'h66) | 8'h18))
      else $error("port config write wrong");
   chk_pwr_write: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (wr_pwr && !soft_rst) |=> pwr_shadow == ($past(wdata) & 8'h27))
      else $error("power mode write wrong");
   chk_clk_write: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (wr_clk && !soft_rst) |=> clk_shadow == ($past(wdata) & 8'h01))
      else $error("clock write wrong");
   chk_xfer_clear: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      (transfer[0] && clk_en_i) |=> !transfer[0]) else $error("transfer bit stuck");
   chk_en_freeze: assert property (@(posedge ref_clk_i) disable iff (!rst_sync_b)
      !clk_en_i |=> ($stable(port_cfg) && $stable(pwr_active) && $stable(ctrl_o)
      && $stable(rd_data_o))) else $error("state moved while disabled");
endmodule : acrb_bank

// [tb/acrb_host_model.sv]
// link-side access source standing in for the serial front end
// assumes: link_clk_i runs free; the caller keeps accesses spaced
module acrb_host_model
   import acrb_pkg::*;
(
   input  wire logic link_clk_i,
   output logic      acc_stb_o,
   output acrb_req_t acc_req_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      acc_stb_o = 1'b0;
      acc_req_o = '0;
   end

   // one strobed access, held across one rising edge
   task automatic send(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(negedge link_clk_i);
      acc_stb_o = 1'b1;
      acc_req_o = '{wr: wr, addr: addr, data: data};
      @(negedge link_clk_i);
      acc_stb_o = 1'b0;
      // released request shows no stale value
      acc_req_o = ~acc_req_o;
   endtask : send
endmodule : acrb_host_model

// [tb/testbench.sv]
// self-checking bench for the adc config register bank
// assumes: accesses reach the bank through the link-side host model
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import acrb_pkg::*;

   logic       ref_clk  = 1'b0;
   logic       link_clk = 1'b0;
   logic       rst_b    = 1'b0;
   logic       clk_en   = 1'b1;
   logic       pin      = 1'b0;
   logic       acc_stb;
   acrb_req_t  acc_req;
   logic [7:0] rd_data;
   logic       rd_valid;
   acrb_ctrl_t ctrl;
   int         n_errors    = 0;
   int         comparisons = 0;
   localparam acrb_ctrl_t CTRL_RST = '{ACRB_PWR_NORMAL, 1'b1, 1'b0};
   localparam logic [7:0] GRADE_RD = {4'h0, GRADE_CODE, 3'h0};
   acrb_pwr_t  pwr_exp [4] = '{ACRB_PWR_NORMAL, ACRB_PWR_FULL_DOWN,
                               ACRB_PWR_STANDBY, ACRB_PWR_NORMAL};

   initial forever #20 ref_clk = ~ref_clk;
   initial begin
      #3;
      forever #6 link_clk = ~link_clk;
   end

   acrb_host_model i_host (
      .link_clk_i (link_clk),
      .acc_stb_o  (acc_stb),
      .acc_req_o  (acc_req)
   );

   acrb_bank i_dut (
      .ref_clk_i        (ref_clk),
      .rst_b_i          (rst_b),
      .clk_en_i         (clk_en),
      .link_clk_i       (link_clk),
      .acc_stb_i        (acc_stb),
      .acc_req_i        (acc_req),
      .power_down_pin_i (pin),
      .rd_data_o        (rd_data),
      .rd_valid_o       (rd_valid),
      .ctrl_o           (ctrl)
   );

   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk8

   task automatic chkc(input string what, input acrb_ctrl_t exp);
      comparisons++;
      if (ctrl !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, ctrl);
      end
   endtask : chkc

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host.send(1'b1, a, d);
      repeat (12) @(negedge ref_clk);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      int i;
      i_host.send(1'b0, a, 8'h00);
      for (i = 0; i < 40 && rd_valid !== 1'b1; i++) @(negedge ref_clk);
      chk8("rd_valid", 8'h01, {7'h00, rd_valid});
      chk8($sformatf("reg %h", a), exp, rd_data);
      repeat (8) @(negedge ref_clk);
   endtask : rd

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : conclude

   initial begin
      #100us;
      n_errors++;
      $display("[ERR] watchdog expected done seen hang");
      conclude();
   end

   initial begin
      repeat (6) @(negedge ref_clk);
      rst_b = 1'b1;
      repeat (8) @(negedge ref_clk);
      chkc("ctrl reset", CTRL_RST); // outputs default
      rd(ADDR_PORT_CFG, RST_PORT_CFG); // default
      rd(ADDR_PART_ID, PART_ID_VALUE); // identifier
      rd(ADDR_GRADE, GRADE_RD); // grade
      rd(ADDR_PWR_MODE, RST_PWR_MODE); // default
      rd(ADDR_CLK_COND, RST_CLK_COND); // default
      rd(ADDR_TRANSFER, RST_TRANSFER); // default
      rd(8'h05, 8'h00); // unmapped
      $display("test defaults done");

      wr(ADDR_PART_ID, 8'hFF); // ignored
      wr(ADDR_GRADE, 8'hFF); // ignored
      rd(ADDR_PART_ID, PART_ID_VALUE); // fixed
      rd(ADDR_GRADE, GRADE_RD); // fixed
      wr(ADDR_CLK_COND, 8'hFE); // unused bits
      rd(ADDR_CLK_COND, 8'h00); // masked
      chkc("dcs before commit", CTRL_RST); // shadow held
      wr(ADDR_TRANSFER, 8'h01); // commit
      chkc("dcs off", '{ACRB_PWR_NORMAL, 1'b0, 1'b0}); // disabled
      rd(ADDR_TRANSFER, 8'h00); // bit clears
      wr(ADDR_CLK_COND, 8'h01); // enable
      wr(ADDR_TRANSFER, 8'h01); // commit
      $display("test access done");

      for (int m = 0; m < 4; m++) begin
         wr(ADDR_PWR_MODE, 8'(m)); // unused zero
         wr(ADDR_TRANSFER, 8'h01); // commit
         chkc("power mode", '{pwr_exp[m], 1'b1, 1'b0}); // decode
      end
      $display("test modes done");

      pin = 1'b1;
      repeat (6) @(negedge ref_clk);
      chkc("pin full", '{ACRB_PWR_FULL_DOWN, 1'b1, 1'b0}); // override
      wr(ADDR_PWR_MODE, 8'h23);
      wr(ADDR_TRANSFER, 8'h01);
      chkc("pin standby", '{ACRB_PWR_STANDBY, 1'b1, 1'b0}); // bit five
      rd(ADDR_PWR_MODE, 8'h23); // readback
      pin = 1'b0;
      repeat (6) @(negedge ref_clk);
      chkc("pin released", CTRL_RST); // released
      clk_en = 1'b0;
      pin    = 1'b1;
      repeat (6) @(negedge ref_clk);
      chkc("frozen", CTRL_RST); // held while disabled
      clk_en = 1'b1;
      repeat (6) @(negedge ref_clk);
      chkc("pin after enable", '{ACRB_PWR_STANDBY, 1'b1, 1'b0}); // bit five
      pin = 1'b0;
      repeat (6) @(negedge ref_clk);
      chkc("pin released again", CTRL_RST); // released
      $display("test pin done");

      wr(ADDR_PORT_CFG, 8'h5A); // mirrored
      rd(ADDR_PORT_CFG, 8'h5A); // lsb bits
      chkc("lsb first", '{ACRB_PWR_NORMAL, 1'b1, 1'b1}); // lsb output
      wr(ADDR_CLK_COND, 8'h00);
      wr(ADDR_TRANSFER, 8'h01);
      wr(ADDR_PORT_CFG, 8'h3C); // soft reset
      rd(ADDR_PORT_CFG, RST_PORT_CFG); // self clear
      rd(ADDR_PWR_MODE, RST_PWR_MODE); // defaults
      rd(ADDR_CLK_COND, RST_CLK_COND); // defaults
      chkc("soft reset", CTRL_RST); // active defaults
      $display("test soft reset done");
      conclude();
   end
endmodule : testbench
